/* File: kws_wakeup.sv */
// Key wakeup and standby release logic with an AHB-Lite register slave.
// Assumes a single-slave AHB-Lite bus; pins arrive asynchronously and this
// block sits in the always-on domain so hclk keeps running in standby.
//
// Functional notes
// - Each aux wake pin has its own enable
// - Enables in key_wake_enable bits 7..4
// - Enables write-only, reset to zero
// - Level mode: enabled aux low releases standby
// - High release pin or low enabled aux at entry skips standby, in both modes
// - Release pin high level or rising edge
// - Release pin always active, no enable
`timescale 1ns/100ps

module kws_wakeup #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Wake pins, asynchronous
	input wire logic release_pin,
	input wire logic aux_wake_pin_a,
	input wire logic aux_wake_pin_b,
	input wire logic aux_wake_pin_c,
	input wire logic aux_wake_pin_d,
	// Standby control
	output logic in_standby,
	output logic warmup_start
);

	kws_pkg::kws_regs_t r;
	kws_pkg::kws_regs_t next_r;
	logic [4:0] pins;
	logic addr_take;
	logic [7:0] addr_idx;
	logic rel_level_hit;
	logic rel_rise;
	logic aux_hit;
	logic release_now;
	logic stop_req;

	////////////////////////////////////////////////////////////////////////
	// Enabled aux pin seen low; used for entry check and for release
	function automatic logic aux_wake_hit(input logic [3:0] en,
		input logic [3:0] lvl);
		aux_wake_hit = |(en & ~lvl);
	endfunction

	// Read mux; write-only and unmapped words read as zero
	function automatic logic [31:0] read_word(input logic [7:0] idx,
		input kws_pkg::kws_regs_t s);
		logic [31:0] w;
		w = kws_pkg::KWS_WORD_ZERO;
		case (idx)
			kws_pkg::KWS_IDX_SYSTEM_CONTROL_ONE: begin
				w[kws_pkg::KWS_SC_RELEASE_LEVEL] = s.release_level;
			end
			kws_pkg::KWS_IDX_STATUS: begin
				w[kws_pkg::KWS_ST_STANDBY] = s.in_standby;
				w[kws_pkg::KWS_ST_RELEASE_LEVEL] = s.release_level;
				w[kws_pkg::KWS_ST_RELEASE_PIN] =
					s.filt[kws_pkg::KWS_PIN_RELEASE];
				w[kws_pkg::KWS_ST_WARMUP] = s.warmup_start;
				w[kws_pkg::KWS_ST_AUX_MSB:kws_pkg::KWS_ST_AUX_LSB] =
					s.filt[kws_pkg::KWS_NUM_AUX-1:0];
			end
			default: begin
				// Enable register is write-only, so it reads zero
				w = kws_pkg::KWS_WORD_ZERO;
			end
		endcase
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin gathering
	assign pins = {release_pin, aux_wake_pin_d, aux_wake_pin_c,
		aux_wake_pin_b, aux_wake_pin_a};

	assign addr_take = hsel & hready & htrans[1];
	assign addr_idx = haddr[9:2];

	// Release pin has no enable and always counts
	assign rel_level_hit = r.filt[kws_pkg::KWS_PIN_RELEASE];
	assign rel_rise = r.filt[kws_pkg::KWS_PIN_RELEASE] & ~r.rel_prev;
	assign aux_hit = aux_wake_hit(r.wake_en,
		r.filt[kws_pkg::KWS_NUM_AUX-1:0]);

	// Level mode: high release pin or low enabled aux; edge mode: rising
	// edge only, aux pins are left to software to keep quiet
	assign release_now = r.release_level ?
		(rel_level_hit | aux_hit) : rel_rise;

	assign stop_req = r.wr_pend &
		(r.wr_idx == kws_pkg::KWS_IDX_SYSTEM_CONTROL_ONE) &
		hwdata[kws_pkg::KWS_SC_STOP_REQUEST];

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_r = r;
		next_r.warmup_start = 1'b0;
		next_r.hreadyout = 1'b1;
		// Response is always OKAY
		next_r.hresp = 1'b0;

		// Three-stage synchroniser; a change counts once stages 2, 3 agree
		next_r.sync1 = pins;
		next_r.sync2 = r.sync1;
		next_r.sync3 = r.sync2;
		for (int i = 0; i < kws_pkg::KWS_NUM_PINS; i++) begin
			if (r.sync2[i] == r.sync3[i]) begin
				next_r.filt[i] = r.sync3[i];
			end
		end
		next_r.rel_prev = r.filt[kws_pkg::KWS_PIN_RELEASE];

		// Data phase writes
		next_r.wr_pend = 1'b0;
		if (r.wr_pend) begin
			case (r.wr_idx)
				kws_pkg::KWS_IDX_KEY_WAKE_ENABLE: begin
					next_r.wake_en = hwdata[kws_pkg::KWS_WAKE_EN_MSB:
						kws_pkg::KWS_WAKE_EN_LSB];
				end
				kws_pkg::KWS_IDX_SYSTEM_CONTROL_ONE: begin
					next_r.release_level =
						hwdata[kws_pkg::KWS_SC_RELEASE_LEVEL];
				end
				default: begin
					next_r.wr_pend = 1'b0;
				end
			endcase
		end

		// Address phase; read data is ready for the very next edge
		if (addr_take) begin
			next_r.wr_pend = hwrite;
			next_r.wr_idx = addr_idx;
			if (!hwrite) begin
				next_r.hrdata = read_word(addr_idx, r);
			end
		end

		// Standby sequencing
		case (r.state)
			kws_pkg::KWS_RUN: begin
				if (stop_req) begin
					// Pending wake at entry goes straight to warm-up
					if (rel_level_hit | aux_hit) begin
						next_r.state = kws_pkg::KWS_WARMUP;
						next_r.warmup_start = 1'b1;
					end else begin
						next_r.state = kws_pkg::KWS_STANDBY;
						next_r.in_standby = 1'b1;
					end
				end
			end
			kws_pkg::KWS_STANDBY: begin
				if (release_now) begin
					next_r.state = kws_pkg::KWS_WARMUP;
					next_r.in_standby = 1'b0;
					next_r.warmup_start = 1'b1;
				end
			end
			kws_pkg::KWS_WARMUP: begin
				// One cycle guard so a stale request cannot re-enter
				next_r.state = kws_pkg::KWS_RUN;
			end
			default: begin
				next_r.state = kws_pkg::KWS_RUN;
				next_r.in_standby = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r.wr_pend <= 1'b0;
			r.wr_idx <= 8'h00;
			r.wake_en <= kws_pkg::KWS_WAKE_EN_RST;
			r.release_level <= kws_pkg::KWS_RELEASE_LEVEL_RST;
			r.state <= kws_pkg::KWS_RUN;
			r.in_standby <= 1'b0;
			r.warmup_start <= 1'b0;
			r.sync1 <= kws_pkg::KWS_PIN_RST;
			r.sync2 <= kws_pkg::KWS_PIN_RST;
			r.sync3 <= kws_pkg::KWS_PIN_RST;
			r.filt <= kws_pkg::KWS_PIN_RST;
			r.rel_prev <= 1'b0;
			r.hrdata <= kws_pkg::KWS_WORD_ZERO;
			r.hreadyout <= 1'b1;
			r.hresp <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign hrdata = r.hrdata;
	assign hreadyout = r.hreadyout;
	assign hresp = r.hresp;
	assign in_standby = r.in_standby;
	assign warmup_start = r.warmup_start;

endmodule // kws_wakeup

/* File: kws_pkg.sv */
// Constants, register map and state types for the key wakeup block.
// Assumes one 25 MHz AHB-Lite clock domain and word-aligned registers.
package kws_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [7:0] KWS_IDX_KEY_WAKE_ENABLE = 8'h31;
	localparam logic [7:0] KWS_IDX_SYSTEM_CONTROL_ONE = 8'h32;
	localparam logic [7:0] KWS_IDX_STATUS = 8'h33;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int KWS_WAKE_EN_LSB = 4;
	localparam int KWS_WAKE_EN_MSB = 7;
	localparam int KWS_SC_RELEASE_LEVEL = 0;
	localparam int KWS_SC_STOP_REQUEST = 1;
	localparam int KWS_ST_STANDBY = 0;
	localparam int KWS_ST_RELEASE_LEVEL = 1;
	localparam int KWS_ST_RELEASE_PIN = 2;
	localparam int KWS_ST_WARMUP = 3;
	localparam int KWS_ST_AUX_LSB = 4;
	localparam int KWS_ST_AUX_MSB = 7;

	////////////////////////////////////////////////////////////////////////
	// Pin vector layout: aux pins a..d in bits 0..3, release pin on top
	localparam int KWS_NUM_AUX = 4;
	localparam int KWS_PIN_RELEASE = 4;
	localparam int KWS_NUM_PINS = 5;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [3:0] KWS_WAKE_EN_RST = 4'h0;
	localparam logic KWS_RELEASE_LEVEL_RST = 1'b0;
	localparam logic [4:0] KWS_PIN_RST = 5'h00;
	localparam logic [31:0] KWS_WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		KWS_RUN = 2'b00,
		KWS_STANDBY = 2'b01,
		KWS_WARMUP = 2'b11
	} kws_state_t;

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [3:0] wake_en;
		logic release_level;
		kws_state_t state;
		logic in_standby;
		logic warmup_start;
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] sync3;
		logic [4:0] filt;
		logic rel_prev;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} kws_regs_t;

endpackage

/* File: kws_monitor.sv */
// Checker on the key wakeup ports.
// Assumes hready is the slave's own hreadyout.
`timescale 1ns/100ps
module kws_monitor #(parameter int ADDR_W = 12) (
	// Clock, reset, bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Pins and state
	input wire logic release_pin,
	input wire logic aux_wake_pin_a,
	input wire logic aux_wake_pin_b,
	input wire logic aux_wake_pin_c,
	input wire logic aux_wake_pin_d,
	input wire logic in_standby,
	input wire logic warmup_start
);
	logic ph, pw, lv;
	logic [ADDR_W-1:0] pa;
	logic [3:0] en;
	wire [3:0] aux = {aux_wake_pin_d, aux_wake_pin_c, aux_wake_pin_b,
		aux_wake_pin_a};
	wire key = |(en & ~aux);
	wire stop = ph && pw && pa == 12'hc8 && hwdata[1] && !in_standby
		&& !warmup_start;
	// Shadow of the enables, as reads give nothing back
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) {ph, pw, pa, en, lv} <= '0;
		else if (hready) begin
			ph <= hsel && htrans[1];
			pw <= hwrite;
			pa <= haddr;
			if (ph && pw && pa == 12'hc4) en <= hwdata[7:4];
			if (ph && pw && pa == 12'hc8) lv <= hwdata[0];
		end
	//////////////////////////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Six cycles leave slack over the five-edge pin pipeline
	sequence hi6; release_pin [*6]; endsequence
	sequence quiet7; (!release_pin && !(lv && key)) [*7]; endsequence
	wo_zero_a: assert property (ph && !pw && pa == 12'hc4
		|-> hrdata == 32'h0) else $error("enable readback not zero");
	aux_level_a: assert property (in_standby ##0 (lv && key) [*6]
		|=> !in_standby) else $error("aux low did not release");
	aux_gate_a: assert property (quiet7 ##0 in_standby
		|=> in_standby) else $error("left standby unprompted");
	rel_level_a: assert property (in_standby ##0 hi6
		|=> !in_standby) else $error("release pin ignored");
	skip_rel_a: assert property (hi6 ##1 (release_pin && stop)
		|=> warmup_start && !in_standby) else $error("no skip on pin");
	skip_aux_a: assert property (key [*7] ##0 stop
		|=> warmup_start) else $error("no skip on aux");
	enter_a: assert property ((!release_pin && !key) [*7] ##0 stop
		|=> in_standby) else $error("standby not entered");
	pulse_a: assert property (warmup_start |=> !warmup_start
		&& !in_standby) else $error("warm-up pulse too long");
endmodule // kws_monitor
bind kws_wakeup kws_monitor #(.ADDR_W(ADDR_W)) mon (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.release_pin(release_pin), .aux_wake_pin_a(aux_wake_pin_a),
	.aux_wake_pin_b(aux_wake_pin_b), .aux_wake_pin_c(aux_wake_pin_c),
	.aux_wake_pin_d(aux_wake_pin_d), .in_standby(in_standby),
	.warmup_start(warmup_start));

/* File: kws_keys.sv */
// Keys and switches on the wake pins.
// Assumes the bench names the wanted levels; keys settle a cycle later.
`timescale 1ns/100ps
module kws_keys (
	// Clock and bench command
	input wire logic hclk,
	input wire logic [4:0] want,
	// Release pin on top, aux a..d below
	output logic release_pin,
	output logic [3:0] aux
);
	//////////////////////////////////////////////////////////////
	// Release rests low, enabled aux rest high
	// Plain digital inputs only
	initial {release_pin, aux} = 5'h0f;
	always @(posedge hclk) {release_pin, aux} <= want;
endmodule // kws_keys

/* File: tb.sv */
// Bench for the key wakeup block over AHB-Lite.
// Assumes the key model on the pins and a zero-wait slave.
`timescale 1ns/100ps
module tb;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [11:0] haddr = 12'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q;
	logic [4:0] want = 5'h0f;
	logic [3:0] aux, m;
	logic hready, hresp, release_pin, in_standby, warmup_start;
	int errors = 0;
	int total_checks = 0;
	always #20 hclk = ~hclk;
	kws_keys keys (.hclk, .want, .release_pin, .aux);
	kws_wakeup dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready),
		.hresp, .release_pin, .aux_wake_pin_a(aux[0]),
		.aux_wake_pin_b(aux[1]), .aux_wake_pin_c(aux[2]),
		.aux_wake_pin_d(aux[3]), .in_standby, .warmup_start);
	//////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t got %h", $time, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		{hsel, haddr, htrans, hwrite} <= {1'h1, a, 2'h2, w};
		do @(posedge hclk); while (hready !== 1'h1 && ++n < 9);
		{hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
		do @(posedge hclk); while (hready !== 1'h1 && ++n < 9);
		q = hrdata;
		// Every transfer must end OKAY
		chk({31'h0, hresp}, 32'h0);
		if (n > 8) begin
			errors++;
			end_of_test();
		end
	endtask
	// Status word from standby, mode and settled pins
	function automatic logic [31:0] st(logic sb, logic lv, logic [4:0] p);
		return {24'h0, p[3:0], 1'h0, p[4], lv, sb};
	endfunction
	initial begin
		void'($urandom(32'h2d28b953));
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		repeat (6) @(posedge hclk);
		bus(1'h0, 12'hc4, 32'h0); chk(q, 32'h0);
		bus(1'h0, 12'hcc, 32'h0); chk(q, st(0, 0, want));
		bus(1'h0, 12'h100, 32'h0); chk(q, 32'h0);
		for (int i = 0; i < 4; i++) begin
			m = 4'($urandom()) & ~(4'h1 << i);
			bus(1'h1, 12'hc4, {24'h0, m, 4'h0});
			bus(1'h1, 12'hc8, 32'h1);
			bus(1'h0, 12'hcc, 32'h0); chk(q, st(0, 1, want));
			bus(1'h1, 12'hc8, 32'h3);
			#1 chk(32'(in_standby), 32'h1);
			@(posedge hclk) want[i] <= 1'h0;
			repeat (8) @(posedge hclk);
			chk(32'(in_standby), 32'h1);
			bus(1'h1, 12'hc4, {24'h0, m | (4'h1 << i), 4'h0});
			repeat (8) @(posedge hclk);
			chk(32'(in_standby), 32'h0);
			bus(1'h0, 12'hcc, 32'h0); chk(q, st(0, 1, want));
			bus(1'h1, 12'hc8, 32'h3);
			#1 chk(32'(warmup_start), 32'h1);
			@(posedge hclk) want[i] <= 1'h1;
			repeat (8) @(posedge hclk);
		end
		// Edge mode needs aux keys off
		bus(1'h1, 12'hc4, 32'h0);
		for (int md = 0; md < 2; md++) begin
			bus(1'h1, 12'hc8, 32'(md));
			bus(1'h1, 12'hc8, 32'(md) | 32'h2);
			#1 chk(32'(in_standby), 32'h1);
			@(posedge hclk) want[4] <= 1'h1;
			repeat (8) @(posedge hclk);
			chk(32'(in_standby), 32'h0);
			bus(1'h1, 12'hc8, 32'(md) | 32'h2);
			#1 chk(32'(warmup_start), 32'h1);
			@(posedge hclk) want[4] <= 1'h0;
			repeat (8) @(posedge hclk);
		end
		bus(1'h1, 12'hc8, 32'h2);
		hresetn <= 1'h0;
		#41 chk(32'(in_standby), 32'h0);
		@(posedge hclk) hresetn <= 1'h1;
		// Pin filter needs four edges after reset before status is valid
		repeat (5) @(posedge hclk);
		bus(1'h0, 12'hcc, 32'h0); chk(q, st(0, 0, want));
		end_of_test();
	end
endmodule // tb
